// ---- dv/drps_lamp.sv ----
`timescale 1ns/1ns
module drps_lamp (
   input wire clk,
   input wire relay1,
   input wire relay2,
   output reg lampFault,
   output reg lampRun
);
   // coil pull-in modelled as one cycle of lag
   always @(posedge clk)
   begin
      lampFault <= !relay1;
      lampRun <= relay2;
   end
endmodule

// ---- dv/drps_props.sv ----
`timescale 1ns/1ns
module drps_props (
   input wire clk,
   input wire nrst,
   input wire initDone,
   input wire modRunning,
   input wire modForward,
   input wire localState,
   input wire forwardOnly,
   input wire [3:0] restartCount,
   input wire [1:0] standstillA,
   input wire relay1,
   input wire relay2,
   input wire autoRestart,
   input wire dirReverse,
   input wire holdEnable,
   input wire faultActive,
   input wire [3:0] relay1Code,
   input wire [3:0] relay2Code
);
   // four samples span the decode and relay register stages
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_none_off: assert property ((relay1Code == 4'ha) [*4] |-> !relay1)
      else $error("relay1 on under code none");
   chk_power_on: assert property ((relay1Code == 4'h2 && initDone) [*4] |-> relay1)
      else $error("relay1 off under code power");
   chk_unused_off: assert property ((relay1Code == 4'h0 || relay1Code > 4'hb) [*4] |-> !relay1)
      else $error("relay1 on under unused code");
   chk_run_relay2: assert property ((relay2Code == 4'h7 && modRunning) [*4] |-> relay2)
      else $error("relay2 off while running");
   chk_fault_off: assert property ((relay1Code == 4'h1 && faultActive) [*4] |-> !relay1)
      else $error("relay1 on during fault");
   chk_fwd_off: assert property ((relay1Code == 4'h6 && modRunning && modForward) [*4] |-> !relay1)
      else $error("relay1 on while running forward");
   chk_local_off: assert property ((relay1Code == 4'h9 && localState) [*4] |-> !relay1)
      else $error("relay1 on in local state");
   chk_restart_off: assert property (autoRestart |-> restartCount != 4'h0)
      else $error("restart with count off");
   chk_forward_only: assert property (forwardOnly |-> !dirReverse)
      else $error("reverse under forward only");
   chk_hold_off: assert property (standstillA == 2'h0 |-> !holdEnable)
      else $error("hold enabled with setting off");
   cover property (relay1Code == 4'h3 && relay1);
   cover property (relay1Code == 4'hb && faultActive);
   cover property (autoRestart);
endmodule
bind drps_supervisor drps_props u_drps_props (.*);

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   reg clk = 0, nrst = 0, factoryReset = 0, codeWrite = 0, codeSel = 0, overCurrentLimit = 0;
   reg modRunning = 0, modForward = 0, localState = 0, initDone = 0, faultUv = 0, faultOv = 0;
   reg faultOc = 0, faultUnit = 0, analogLossRaw = 0, analogLossDetectEnable = 1;
   reg liveZeroMode = 0, keypadReset = 0, startIn = 1, forwardOnly = 0, dirCmdReverse = 0;
   reg [3:0] codeIn = 4'h0, restartCount = 4'h0;
   reg [11:0] outFreq = 12'h000, freqSupervisionLimit = 12'h0c8;
   reg [11:0] motorCurrent = 12'h000, motorCurrentNominal = 12'h100;
   reg [7:0] thermalProtectBreakFreq = 8'h00;
   reg [1:0] standstillA = 2'h0;
   wire relay1, relay2, faultLedN, faultActive, faultLatched, autoRestart, overTempTrip;
   wire useMinReference, analogFaultRecord, dirReverse, holdEnable, holdStrong;
   wire lampFault, lampRun;
   wire [3:0] restartsLeft, relay1Code, relay2Code;
   integer error_cnt = 0, check_count = 0, cyc = 0, i;
   localparam [15:0] RELAY_ON = 16'h0196;
   drps_supervisor #(.ILIM_HOLD_CYC(24'h000032)) u_drps_supervisor (.*);
   drps_lamp u_drps_lamp (.*);
   initial forever #10 clk = ~clk;
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt = error_cnt + 1;
         complete_run;
      end
   end
   task chk(input string n, input [11:0] e, input [11:0] g);
      check_count = check_count + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task wt(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task setcode(input [3:0] c);
      @(posedge clk);
      codeWrite <= 1'b1;
      codeIn <= c;
      @(posedge clk);
      codeWrite <= 1'b0;
      wt(4);
   endtask
   task fq(input [11:0] f, input [11:0] e);
      @(posedge clk);
      outFreq <= f;
      wt(5);
      chk("relay1", e, {11'h000, relay1});
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      wt(2);
      chk("relay1Code", 12'h001, {8'h00, relay1Code});
      chk("relay2Code", 12'h007, {8'h00, relay2Code});
      @(posedge clk);
      initDone <= 1'b1;
      modRunning <= 1'b1;
      modForward <= 1'b1;
      localState <= 1'b1;
      wt(6);
      chk("lampRun", 12'h001, {11'h000, lampRun});
      $display("test reset done");
      for (i = 0; i < 16; i = i + 1)
      begin
         setcode(i[3:0]);
         chk("relay1", {11'h000, RELAY_ON[i]}, {11'h000, relay1});
      end
      @(posedge clk);
      codeSel <= 1'b1;
      setcode(4'ha);
      chk("relay2Code", 12'h00a, {8'h00, relay2Code});
      chk("relay2", 12'h000, {11'h000, relay2});
      chk("lampRun", 12'h000, {11'h000, lampRun});
      @(posedge clk);
      codeSel <= 1'b0;
      $display("test codes done");
      setcode(4'h4);
      fq(12'h0d2, 12'h000);
      fq(12'h0be, 12'h000);
      fq(12'h0b3, 12'h001);
      @(posedge clk);
      freqSupervisionLimit <= 12'h032;
      fq(12'h03c, 12'h000);
      fq(12'h029, 12'h000);
      fq(12'h027, 12'h001);
      setcode(4'h5);
      fq(12'h03b, 12'h000);
      fq(12'h03d, 12'h001);
      $display("test frequency done");
      setcode(4'h3);
      @(posedge clk);
      overCurrentLimit <= 1'b1;
      @(posedge clk);
      overCurrentLimit <= 1'b0;
      wt(30);
      chk("relay1", 12'h001, {11'h000, relay1});
      wt(40);
      chk("relay1", 12'h000, {11'h000, relay1});
      setcode(4'h1);
      @(posedge clk);
      faultOv <= 1'b1;
      @(posedge clk);
      faultOv <= 1'b0;
      wt(5);
      chk("faultLatched", 12'h001, {11'h000, faultLatched});
      chk("relay1", 12'h000, {11'h000, relay1});
      chk("faultLedN", 12'h000, {11'h000, faultLedN});
      setcode(4'hb);
      chk("relay1", 12'h001, {11'h000, relay1});
      @(posedge clk);
      keypadReset <= 1'b1;
      repeat (4) @(posedge clk);
      keypadReset <= 1'b0;
      wt(5);
      chk("faultActive", 12'h000, {11'h000, faultActive});
      $display("test fault done");
      @(posedge clk);
      restartCount <= 4'h2;
      @(posedge clk);
      faultUv <= 1'b1;
      @(posedge clk);
      faultUv <= 1'b0;
      wt(1);
      chk("autoRestart", 12'h001, {11'h000, autoRestart});
      chk("restartsLeft", 12'h001, {8'h00, restartsLeft});
      chk("faultActive", 12'h000, {11'h000, faultActive});
      $display("test restart done");
      @(posedge clk);
      dirCmdReverse <= 1'b1;
      analogLossRaw <= 1'b1;
      wt(4);
      chk("dirReverse", 12'h001, {11'h000, dirReverse});
      chk("analogFaultRecord", 12'h001, {11'h000, analogFaultRecord});
      @(posedge clk);
      forwardOnly <= 1'b1;
      dirCmdReverse <= 1'b1;
      analogLossDetectEnable <= 1'b0;
      liveZeroMode <= 1'b1;
      analogLossRaw <= 1'b1;
      wt(5);
      chk("dirReverse", 12'h000, {11'h000, dirReverse});
      chk("useMinReference", 12'h001, {11'h000, useMinReference});
      chk("analogFaultRecord", 12'h000, {11'h000, analogFaultRecord});
      for (i = 0; i < 3; i = i + 1)
      begin
         @(posedge clk);
         standstillA <= i[1:0];
         wt(2);
         chk("holdEnable", {11'h000, i != 0}, {11'h000, holdEnable});
         chk("holdStrong", {11'h000, i == 2}, {11'h000, holdStrong});
      end
      @(posedge clk);
      factoryReset <= 1'b1;
      @(posedge clk);
      factoryReset <= 1'b0;
      wt(3);
      chk("relay1Code", 12'h001, {8'h00, relay1Code});
      chk("relay2Code", 12'h007, {8'h00, relay2Code});
      $display("test options done");
      complete_run;
   end
endmodule

// ---- logic/drps_defs.vh ----
// Notes on behaviour
// - code 1: fault de-energises relay, lights LED
// - code 2: relay energised after initialisation
// - code 3: over-current energises, minimum 250 ms
// - code 4: off above limit, on below hysteresis
// - hysteresis 2 Hz above 10 Hz, else 20%
// - code 5: off below limit, on above hysteresis
// - code 6: off while modulator runs forward
// - code 7: energised while modulator reports running
// - code 8: off while overtemperature fault active
// - code 9: off while under local control
// - code 10: relay always de-energised
// - code 11: fault energises relay, lights LED
// - factory reset: relay1 fault, relay2 running
// - auto restart listed faults up to count
// - thermal limit off disables overload protection
// - overtemperature trips, reset only when cooled
// - estimate runs when stopped, ambient after power
// - low speed lowers allowed continuous current
// - forward only ignores all direction commands
// - analog loss masked: substitute minimum, no fault; code substitutes only when liveZeroMode
// - keypad reset or start drop clears fault
`ifndef DRPS_DEFS_VH
`define DRPS_DEFS_VH
`define DRPS_CODE_W 4
`define DRPS_FN_FAULT 4'h1
`define DRPS_FN_POWER 4'h2
`define DRPS_FN_ILIM 4'h3
`define DRPS_FN_FOVER 4'h4
`define DRPS_FN_FUNDER 4'h5
`define DRPS_FN_RUNFWD 4'h6
`define DRPS_FN_RUN 4'h7
`define DRPS_FN_OVERTEMP 4'h8
`define DRPS_FN_LOCAL 4'h9
`define DRPS_FN_NONE 4'ha
`define DRPS_FN_FAULTINV 4'hb
`define DRPS_RELAY1_DEFAULT 4'h1
`define DRPS_RELAY2_DEFAULT 4'h7
`define DRPS_FREQ_W 12
`define DRPS_HYST_KNEE 12'h064
`define DRPS_HYST_FIXED 12'h014
`define DRPS_CLK_HZ 50000000
`define DRPS_ILIM_HOLD_MS 250
// 250 ms at 50 MHz, sized to the 24-bit hold counter
`define DRPS_ILIM_HOLD_CYC 24'hbebc20
`define DRPS_TEMP_W 16
`define DRPS_CNT_W 4
`define DRPS_HOLD_OFF 2'h0
`define DRPS_HOLD_NORMAL 2'h1
`define DRPS_HOLD_STRONG 2'h2
`endif

// ---- logic/drps_supervisor.v ----
`timescale 1ns/1ns
`include "drps_defs.vh"
module drps_supervisor #(
   parameter [23:0] ILIM_HOLD_CYC = `DRPS_ILIM_HOLD_CYC
)
(
   input wire clk,
   input wire nrst,
   input wire factoryReset,
   input wire codeWrite,
   input wire codeSel,
   input wire [3:0] codeIn,
   input wire [11:0] outFreq,
   input wire [11:0] freqSupervisionLimit,
   input wire overCurrentLimit,
   input wire modRunning,
   input wire modForward,
   input wire localState,
   input wire initDone,
   input wire faultUv,
   input wire faultOv,
   input wire faultOc,
   input wire faultUnit,
   input wire analogLossRaw,
   input wire analogLossDetectEnable,
   input wire liveZeroMode,
   input wire [3:0] restartCount,
   input wire keypadReset,
   input wire startIn,
   input wire [7:0] thermalProtectBreakFreq,
   input wire [11:0] motorCurrent,
   input wire [11:0] motorCurrentNominal,
   input wire forwardOnly,
   input wire dirCmdReverse,
   input wire [1:0] standstillA,
   output reg relay1,
   output reg relay2,
   output reg faultLedN,
   output reg faultActive,
   output reg faultLatched,
   output reg autoRestart,
   output reg overTempTrip,
   output reg useMinReference,
   output reg analogFaultRecord,
   output reg dirReverse,
   output reg holdEnable,
   output reg holdStrong,
   output reg [3:0] restartsLeft,
   output reg [3:0] relay1Code,
   output reg [3:0] relay2Code
);

// -----------------------------------------------
// pin synchronisers
// -----------------------------------------------
reg startPrev_q;
wire [2:0] pinRaw = {analogLossRaw, startIn, keypadReset};
wire [2:0] pinSync;
wire kpS = pinSync[0];
wire stS = pinSync[1];
wire alS = pinSync[2];
genvar g;
// one two-stage synchroniser per asynchronous pin
generate
   for (g = 0; g < 3; g = g + 1)
   begin : gSync
      reg [1:0] sync_q;
      always @(posedge clk or negedge nrst)
      begin
         if (!nrst)
            sync_q <= 2'h0;
         else
            sync_q <= {sync_q[0], pinRaw[g]};
      end
      assign pinSync[g] = sync_q[1];
   end
endgenerate

// start edge detector reads only the second stage
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      startPrev_q <= 1'b0;
   else
      startPrev_q <= stS;
end

// -----------------------------------------------
// function code store
// -----------------------------------------------
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      relay1Code <= `DRPS_RELAY1_DEFAULT;
      relay2Code <= `DRPS_RELAY2_DEFAULT;
   end
   else if (factoryReset)
   begin
      relay1Code <= `DRPS_RELAY1_DEFAULT;
      relay2Code <= `DRPS_RELAY2_DEFAULT;
   end
   else if (codeWrite)
   begin
      if (codeSel)
         relay2Code <= codeIn;
      else
         relay1Code <= codeIn;
   end
end

// -----------------------------------------------
// frequency supervision
// -----------------------------------------------
// 0.1 Hz units: knee 10 Hz, fixed band 2 Hz
wire [11:0] hyst = (freqSupervisionLimit > `DRPS_HYST_KNEE) ? `DRPS_HYST_FIXED :
   ((freqSupervisionLimit / 12'h005));
wire [12:0] upperBand = {1'b0, freqSupervisionLimit} + {1'b0, hyst};
wire [11:0] lowerBand = freqSupervisionLimit - hyst;
reg overOn_q;
reg underOn_q;
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      overOn_q <= 1'b1;
      underOn_q <= 1'b0;
   end
   else
   begin
      if (outFreq > freqSupervisionLimit)
         overOn_q <= 1'b0;
      else if (outFreq < lowerBand)
         overOn_q <= 1'b1;
      if (outFreq < freqSupervisionLimit)
         underOn_q <= 1'b0;
      else if ({1'b0, outFreq} > upperBand)
         underOn_q <= 1'b1;
   end
end

// -----------------------------------------------
// current limit stretch
// -----------------------------------------------
reg [23:0] ilimCnt_q;
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      ilimCnt_q <= 24'h0;
   else if (overCurrentLimit)
      ilimCnt_q <= ILIM_HOLD_CYC;
   else if (ilimCnt_q != 24'h0)
      ilimCnt_q <= ilimCnt_q - 24'h1;
end
// held while limited, then for the minimum after release
wire ilimOn = overCurrentLimit || (ilimCnt_q != 24'h0);

// -----------------------------------------------
// thermal model (simplified accumulator)
// -----------------------------------------------
reg [15:0] temp_q;
wire protEnable = (thermalProtectBreakFreq != 8'h0);
// below break frequency allowance drops to three quarters of nominal
wire lowSpeed = (outFreq[11:4] < thermalProtectBreakFreq);
wire [11:0] allowed = lowSpeed ? (motorCurrentNominal - (motorCurrentNominal >> 2))
   : motorCurrentNominal;
wire heating = motorCurrent > allowed;
wire cooled = (temp_q < 16'h4000);
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      temp_q <= 16'h0;
   else if (!protEnable)
      temp_q <= 16'h0;
   else if (heating && temp_q != 16'hffff)
      temp_q <= temp_q + 16'h1;
   else if (!heating && temp_q != 16'h0)
      temp_q <= temp_q - 16'h1;
end
wire overTempCond = protEnable && (temp_q == 16'hffff);

// -----------------------------------------------
// faults, reset and auto restart
// -----------------------------------------------
wire analogFault = alS && analogLossDetectEnable;
wire restartable = faultUv || faultOv || faultOc || faultUnit || analogFault;
wire resetReq = kpS || (startPrev_q && !stS);

// standstill hold setting decode, shared by both hold outputs
function holdDecode;
   input [1:0] setting;
   input strongOnly;
   begin
      case (setting)
         `DRPS_HOLD_NORMAL: holdDecode = !strongOnly;
         `DRPS_HOLD_STRONG: holdDecode = 1'b1;
         default: holdDecode = 1'b0;
      endcase
   end
endfunction

always @*
begin
   useMinReference = alS && !analogLossDetectEnable && liveZeroMode;
   analogFaultRecord = analogFault;
   dirReverse = forwardOnly ? 1'b0 : dirCmdReverse;
   holdEnable = holdDecode(standstillA, 1'b0);
   holdStrong = holdDecode(standstillA, 1'b1);
end

// new trip wins over a reset in the same cycle
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      overTempTrip <= 1'b0;
   else if (overTempCond)
      overTempTrip <= 1'b1;
   else if (resetReq && cooled)
      overTempTrip <= 1'b0;
end

// -----------------------------------------------
// restart budget
// -----------------------------------------------
// budget reloads only while idle, so a quick re-trip
// after an automatic restart still spends it
wire restartNow = faultActive && !restartable && !overTempCond && !resetReq &&
   !overTempTrip && !faultLatched && (restartsLeft != 4'h0);
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      restartsLeft <= 4'h0;
   else if (restartNow)
      restartsLeft <= restartsLeft - 4'h1;
   else if (!faultActive && !autoRestart && !restartable)
      restartsLeft <= restartCount;
end

always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      autoRestart <= 1'b0;
   else
      autoRestart <= restartNow;
end

// new fault wins over a reset in the same cycle
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      faultActive <= 1'b0;
      faultLatched <= 1'b0;
   end
   else if (restartable || overTempCond)
      faultActive <= 1'b1;
   else if (resetReq && !(overTempTrip && !cooled))
   begin
      faultActive <= 1'b0;
      faultLatched <= 1'b0;
   end
   else if (restartNow)
      faultActive <= 1'b0;
   else if (faultActive && !overTempTrip)
      faultLatched <= 1'b1;
end

// -----------------------------------------------
// relay function decode
// -----------------------------------------------
function relayFn;
   input [3:0] code;
   input fault;
   input power;
   input ilim;
   input fOver;
   input fUnder;
   input runs;
   input fwd;
   input otrip;
   input isLocal;
   begin
      case (code)
         `DRPS_FN_FAULT: relayFn = !fault;
         `DRPS_FN_POWER: relayFn = power;
         `DRPS_FN_ILIM: relayFn = ilim;
         `DRPS_FN_FOVER: relayFn = fOver;
         `DRPS_FN_FUNDER: relayFn = fUnder;
         `DRPS_FN_RUNFWD: relayFn = !(runs && fwd);
         `DRPS_FN_RUN: relayFn = runs;
         `DRPS_FN_OVERTEMP: relayFn = !otrip;
         `DRPS_FN_LOCAL: relayFn = !isLocal;
         `DRPS_FN_FAULTINV: relayFn = fault;
         default: relayFn = 1'b0;
      endcase
   end
endfunction

wire r1d = relayFn(
   relay1Code,
   faultActive,
   initDone,
   ilimOn,
   overOn_q,
   underOn_q,
   modRunning,
   modForward,
   overTempTrip,
   localState
);
wire r2d = relayFn(
   relay2Code,
   faultActive,
   initDone,
   ilimOn,
   overOn_q,
   underOn_q,
   modRunning,
   modForward,
   overTempTrip,
   localState
);

// -----------------------------------------------
// relay output stage
// -----------------------------------------------
// relays are off at power-up so nothing flickers before init
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      relay1 <= 1'b0;
   else if (relay1 != r1d)
      relay1 <= r1d;
end

always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      relay2 <= 1'b0;
   else if (relay2 != r2d)
      relay2 <= r2d;
end

always @(posedge clk or negedge nrst)
begin
   if (!nrst)
      faultLedN <= 1'b1;
   else
      faultLedN <= !faultActive;
end

endmodule
